//--- lowrate_pan_pkg.sv
// Purpose: Shared constants and types for the low-rate PAN frame handler.
// Assumes: A 10 MHz system clock and a 32-bit plain register port.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package lowrate_pan_pkg;

   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned SYMBOL_US = 16;
   localparam int unsigned BITS_PER_SYMBOL = 4;
   localparam int unsigned SYMBOL_CYCLES = (CLK_HZ / 1_000_000) * SYMBOL_US;
   localparam int unsigned BIT_CYCLES = SYMBOL_CYCLES / BITS_PER_SYMBOL;

   localparam logic [7:0] PREAMBLE_OCTETS = 8'h04;
   localparam logic [7:0] SFD_POS = 8'h04;
   localparam logic [7:0] PHR_POS = 8'h05;
   localparam logic [7:0] DATA_POS = 8'h06;
   localparam logic [7:0] SFD_RESET = 8'ha7;
   localparam logic [6:0] CRC_OCTETS = 7'h02;

   // Reflected form of x^16 + x^12 + x^5 + 1, as used with LSB-first octets.
   localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
   localparam logic [15:0] CRC_INIT = 16'h0000;

   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TASK = 8'h04;
   localparam logic [7:0] REG_SFD = 8'h08;
   localparam logic [7:0] REG_FRAME_PTR = 8'h0c;
   localparam logic [7:0] REG_FREQ = 8'h10;
   localparam logic [7:0] REG_PAN_ID = 8'h14;
   localparam logic [7:0] REG_SHORT_ADDR = 8'h18;
   localparam logic [7:0] REG_EXT_LO = 8'h1c;
   localparam logic [7:0] REG_EXT_HI = 8'h20;
   localparam logic [7:0] REG_STATUS = 8'h24;
   localparam logic [7:0] REG_EVENTS = 8'h28;

   localparam int unsigned CTRL_MODE_BIT = 0;
   localparam int unsigned CTRL_CRC_BIT = 1;
   localparam int unsigned CTRL_ASSIST_BIT = 2;
   localparam int unsigned CTRL_RXEN_BIT = 3;
   localparam int unsigned TASK_TXSTART_BIT = 0;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [6:0] FREQ_RESET = 7'h00;

   localparam logic [1:0] ADDR_MODE_SHORT = 2'h2;
   localparam logic [1:0] ADDR_MODE_EXT = 2'h3;
   localparam logic [7:0] IDX_SEQ = 8'h02;
   localparam logic [7:0] IDX_PAN = 8'h03;
   localparam logic [7:0] IDX_ADDR = 8'h05;
   localparam logic [7:0] SHORT_LEN = 8'h02;
   localparam logic [7:0] EXT_LEN = 8'h08;
   localparam logic [7:0] BCAST_OCTET = 8'hff;

   typedef struct packed {
      logic [31:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } mem_req_t;

   typedef struct packed {
      logic [2:0] frame_type;
      logic ack_req;
      logic [1:0] dst_mode;
   } fcf_info_t;

endpackage

//--- lowrate_pan_frame_phy.sv
// Purpose: Frame handler for the 250 kbps O-QPSK low-rate PAN mode.
// Assumes: Bits on the air pins are already demodulated, one bit per strobe.
// Notes: Memory reads answer in the cycle after the read request.
// Operation
// - Link runs only in 250 kbps mode.
// - One symbol lasts 16 microseconds.
// - Send four zero preamble octets first.
// - Delimiter defaults 0xa7, software may replace.
// - Device itself generates preamble and delimiter.
// - Length header follows five-octet sync header.
// - Low seven length bits give payload length.
// - Store all eight length bits unchanged.
// - Length header stored first at frame pointer.
// - Zero length frames dropped, no begin event.
// - Payload octet count equals length value.
// - Payload at most 127 octets.
// - Transmit appends computed 16-bit check sequence.
// - Receive checks sequence, reports result.
// - Assisted mode decodes the frame control field.
// - Sequence number kept for acknowledgement.
// - Addressing field zero to 20 octets.
// - Compare network id and node address.
// - Check sequence uses x16+x12+x5+1 polynomial.
//
// The register offsets and the plain strobed port were left to the implementer.
module lowrate_pan_frame_phy (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [31:0] reg_rdata_o,
   output lowrate_pan_pkg::mem_req_t mem_req_o,
   input wire logic [7:0] mem_rdata_i,
   input wire logic rx_bit_i,
   input wire logic rx_strobe_i,
   output logic tx_bit_o,
   output logic tx_active_o,
   output logic [6:0] freq_setting_o,
   output logic frame_begin_event_o
);

   typedef enum logic [1:0] {RX_HUNT, RX_LEN, RX_DATA} rx_state_t;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[0] ^ b[i]) begin
            r = (r >> 1) ^ lowrate_pan_pkg::CRC_POLY_REFL;
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction

   logic [3:0] ctrl_reg;
   logic [7:0] sfd_reg;
   logic [31:0] ptr_reg;
   logic [6:0] freq_reg;
   logic [15:0] pan_reg;
   logic [15:0] short_reg;
   logic [63:0] ext_reg;
   logic [2:0] events_reg;
   logic [2:0] events_next;

   wire mode_on = ctrl_reg[lowrate_pan_pkg::CTRL_MODE_BIT];
   wire crc_on = ctrl_reg[lowrate_pan_pkg::CTRL_CRC_BIT];
   wire assist_on = ctrl_reg[lowrate_pan_pkg::CTRL_ASSIST_BIT];
   wire rx_on = ctrl_reg[lowrate_pan_pkg::CTRL_RXEN_BIT];

   wire wr_ctrl = reg_write_i && reg_addr_i == lowrate_pan_pkg::REG_CTRL;
   wire wr_task = reg_write_i && reg_addr_i == lowrate_pan_pkg::REG_TASK;
   wire wr_sfd = reg_write_i && reg_addr_i == lowrate_pan_pkg::REG_SFD;
   wire wr_ptr = reg_write_i && reg_addr_i == lowrate_pan_pkg::REG_FRAME_PTR;
   wire wr_freq = reg_write_i && reg_addr_i == lowrate_pan_pkg::REG_FREQ;
   wire wr_pan = reg_write_i && reg_addr_i == lowrate_pan_pkg::REG_PAN_ID;
   wire wr_short = reg_write_i && reg_addr_i == lowrate_pan_pkg::REG_SHORT_ADDR;
   wire wr_extlo = reg_write_i && reg_addr_i == lowrate_pan_pkg::REG_EXT_LO;
   wire wr_exthi = reg_write_i && reg_addr_i == lowrate_pan_pkg::REG_EXT_HI;
   wire wr_events = reg_write_i && reg_addr_i == lowrate_pan_pkg::REG_EVENTS;

   logic rd_wait_reg;
   logic tx_busy_reg;
   logic [7:0] pos_reg;
   logic [2:0] tbit_reg;
   logic [7:0] tsh_reg;
   logic [7:0] nxt_reg;
   logic [6:0] tlen_reg;
   logic [15:0] tcrc_reg;
   logic [5:0] div_reg;
   logic bit_en;

   rx_state_t rx_state_reg;
   logic [2:0] rx_sync_a_reg;
   logic [2:0] rx_sync_b_reg;
   logic [15:0] hunt_reg;
   logic [7:0] rsh_reg;
   logic [2:0] rbit_reg;
   logic [6:0] rlen_reg;
   logic [7:0] idx_reg;
   logic [15:0] rcrc_reg;
   logic [7:0] fcf_lo_reg;
   logic [7:0] fcf_hi_reg;
   logic [7:0] seq_reg;
   logic [7:0] phr_reg;
   logic crc_ok_reg;
   logic match_reg;
   logic pan_own_reg;
   logic pan_bc_reg;
   logic adr_own_reg;
   logic adr_bc_reg;
   logic begin_pulse_reg;

   // Transmit datapath.
   wire tx_start = wr_task && reg_wdata_i[lowrate_pan_pkg::TASK_TXSTART_BIT] && mode_on
      && !tx_busy_reg && rx_state_reg == RX_HUNT;
   assign bit_en = tx_busy_reg && div_reg == 6'(lowrate_pan_pkg::BIT_CYCLES - 1);

   wire [7:0] np = pos_reg + 8'h01;
   wire [7:0] pf = pos_reg + 8'h02;
   wire [6:0] len_now = (np == lowrate_pan_pkg::PHR_POS) ? nxt_reg[6:0] : tlen_reg;
   wire [7:0] np_k = np - lowrate_pan_pkg::DATA_POS;
   wire [7:0] pf_k = pf - lowrate_pan_pkg::DATA_POS;
   wire [7:0] crc_k = {1'b0, tlen_reg - lowrate_pan_pkg::CRC_OCTETS};
   wire [7:0] crc_k_now = {1'b0, len_now - lowrate_pan_pkg::CRC_OCTETS};
   wire np_is_crc = crc_on && np >= lowrate_pan_pkg::DATA_POS && np_k >= crc_k;
   wire np_is_mem = np == lowrate_pan_pkg::PHR_POS || (np >= lowrate_pan_pkg::DATA_POS && !np_is_crc);
   wire pf_is_mem = pf == lowrate_pan_pkg::PHR_POS
      || (pf >= lowrate_pan_pkg::DATA_POS && pf_k < {1'b0, len_now}
      && !(crc_on && pf_k >= crc_k_now));
   wire [31:0] pf_addr = ptr_reg + 32'(pf - lowrate_pan_pkg::PHR_POS);
   wire [7:0] last_pos = lowrate_pan_pkg::PHR_POS + {1'b0, tlen_reg};
   wire tx_last = pos_reg >= lowrate_pan_pkg::PHR_POS && pos_reg == last_pos;
   wire byte_end = bit_en && tbit_reg == 3'h7;

   logic [7:0] np_byte;
   always_comb begin
      if (np < lowrate_pan_pkg::PREAMBLE_OCTETS) begin
         np_byte = 8'h00;
      end else if (np == lowrate_pan_pkg::SFD_POS) begin
         np_byte = sfd_reg;
      end else if (np_is_crc && np_k == crc_k) begin
         np_byte = tcrc_reg[7:0];
      end else if (np_is_crc) begin
         np_byte = tcrc_reg[15:8];
      end else begin
         np_byte = nxt_reg;
      end
   end

   wire tx_prefetch = byte_end && !tx_last && pf_is_mem;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_busy_reg <= 1'b0;
         div_reg <= 6'h00;
      end else begin
         tx_busy_reg <= tx_start || (tx_busy_reg && !(byte_end && tx_last));
         div_reg <= (tx_start || bit_en) ? 6'h00 : div_reg + 6'h01;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pos_reg <= 8'h00;
         tbit_reg <= 3'h0;
         tsh_reg <= 8'h00;
         tlen_reg <= 7'h00;
         tcrc_reg <= lowrate_pan_pkg::CRC_INIT;
      end else if (tx_start) begin
         pos_reg <= 8'h00;
         tbit_reg <= 3'h0;
         tsh_reg <= 8'h00;
         tcrc_reg <= lowrate_pan_pkg::CRC_INIT;
      end else if (byte_end && !tx_last) begin
         pos_reg <= np;
         tbit_reg <= 3'h0;
         tsh_reg <= np_byte;
         if (np == lowrate_pan_pkg::PHR_POS) begin
            tlen_reg <= nxt_reg[6:0];
         end
         if (np >= lowrate_pan_pkg::DATA_POS && !np_is_crc) begin
            tcrc_reg <= crc_step(tcrc_reg, nxt_reg);
         end
      end else if (bit_en) begin
         tbit_reg <= tbit_reg + 3'h1;
         tsh_reg <= {1'b0, tsh_reg[7:1]};
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_wait_reg <= 1'b0;
         nxt_reg <= 8'h00;
      end else begin
         rd_wait_reg <= mem_req_o.re;
         if (rd_wait_reg) nxt_reg <= mem_rdata_i;
      end
   end

   assign tx_bit_o = tsh_reg[0];
   assign tx_active_o = tx_busy_reg;

   // Receive datapath.
   // Both air inputs pass two flops; the third stage only serves edge detection.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_sync_a_reg <= 3'h0;
         rx_sync_b_reg <= 3'h0;
      end else begin
         rx_sync_a_reg <= {rx_sync_a_reg[1:0], rx_bit_i};
         rx_sync_b_reg <= {rx_sync_b_reg[1:0], rx_strobe_i};
      end
   end

   wire rx_bit = rx_sync_a_reg[1];
   wire rx_tick = rx_sync_b_reg[1] && !rx_sync_b_reg[2] && mode_on && rx_on && !tx_busy_reg;
   wire [15:0] hunt_next = {rx_bit, hunt_reg[15:1]};
   wire rx_byte_done = rx_tick && rbit_reg == 3'h7;
   wire [7:0] rx_byte = {rx_bit, rsh_reg[7:1]};
   // A delimiter preceded by a zero octet marks the frame; a changed delimiter filters.
   wire sfd_seen = rx_tick && hunt_next[15:8] == sfd_reg && hunt_next[7:0] == 8'h00;
   wire len_zero = rx_byte[6:0] == 7'h00;
   wire len_take = rx_state_reg == RX_LEN && rx_byte_done && !len_zero;
   wire data_take = rx_state_reg == RX_DATA && rx_byte_done;
   wire [15:0] rcrc_next = crc_step(rcrc_reg, rx_byte);
   wire rx_last = data_take && idx_reg + 8'h01 == {1'b0, rlen_reg};

   wire [1:0] dst_mode = fcf_hi_reg[3:2];
   wire [7:0] addr_k = idx_reg - lowrate_pan_pkg::IDX_ADDR;
   wire in_pan = idx_reg == lowrate_pan_pkg::IDX_PAN || idx_reg == lowrate_pan_pkg::IDX_PAN + 8'h01;
   wire in_short = dst_mode == lowrate_pan_pkg::ADDR_MODE_SHORT
      && idx_reg >= lowrate_pan_pkg::IDX_ADDR && addr_k < lowrate_pan_pkg::SHORT_LEN;
   wire in_ext = dst_mode == lowrate_pan_pkg::ADDR_MODE_EXT
      && idx_reg >= lowrate_pan_pkg::IDX_ADDR && addr_k < lowrate_pan_pkg::EXT_LEN;
   wire [7:0] own_pan_b = idx_reg[0] ? pan_reg[7:0] : pan_reg[15:8];
   wire [7:0] own_short_b = addr_k[0] ? short_reg[15:8] : short_reg[7:0];
   wire [63:0] ext_shift = ext_reg >> {addr_k[2:0], 3'h0};
   wire [7:0] own_adr_b = in_ext ? ext_shift[7:0] : own_short_b;
   wire is_bcast = rx_byte == lowrate_pan_pkg::BCAST_OCTET;
   wire pan_ok = pan_own_reg || pan_bc_reg;
   wire adr_ok = (dst_mode == lowrate_pan_pkg::ADDR_MODE_SHORT && (adr_own_reg || adr_bc_reg))
      || (dst_mode == lowrate_pan_pkg::ADDR_MODE_EXT && adr_own_reg);

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_state_reg <= RX_HUNT;
         hunt_reg <= 16'hffff;
         rsh_reg <= 8'h00;
         rbit_reg <= 3'h0;
      end else if (rx_tick) begin
         rsh_reg <= rx_byte;
         rbit_reg <= rbit_reg + 3'h1;
         hunt_reg <= hunt_next;
         case (rx_state_reg)
            RX_HUNT: begin
               if (sfd_seen) begin
                  rx_state_reg <= RX_LEN;
                  rbit_reg <= 3'h0;
                  hunt_reg <= 16'hffff;
               end
            end
            RX_LEN: begin
               if (rx_byte_done) begin
                  rx_state_reg <= len_zero ? RX_HUNT : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_last) begin
                  rx_state_reg <= RX_HUNT;
               end
            end
            default: begin
               rx_state_reg <= RX_HUNT;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rlen_reg <= 7'h00;
         idx_reg <= 8'h00;
         rcrc_reg <= lowrate_pan_pkg::CRC_INIT;
         phr_reg <= 8'h00;
         begin_pulse_reg <= 1'b0;
      end else begin
         begin_pulse_reg <= len_take;
         if (len_take) begin
            rlen_reg <= rx_byte[6:0];
            phr_reg <= rx_byte;
            idx_reg <= 8'h00;
            rcrc_reg <= lowrate_pan_pkg::CRC_INIT;
         end else if (data_take) begin
            idx_reg <= idx_reg + 8'h01;
            rcrc_reg <= rcrc_next;
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fcf_lo_reg <= 8'h00;
         fcf_hi_reg <= 8'h00;
         seq_reg <= 8'h00;
         pan_own_reg <= 1'b0;
         pan_bc_reg <= 1'b0;
         adr_own_reg <= 1'b0;
         adr_bc_reg <= 1'b0;
      end else if (len_take) begin
         fcf_hi_reg <= 8'h00;
         pan_own_reg <= 1'b1;
         pan_bc_reg <= 1'b1;
         adr_own_reg <= 1'b1;
         adr_bc_reg <= 1'b1;
      end else if (data_take && assist_on) begin
         if (idx_reg == 8'h00) begin
            fcf_lo_reg <= rx_byte;
         end
         if (idx_reg == 8'h01) begin
            fcf_hi_reg <= rx_byte;
         end
         if (idx_reg == lowrate_pan_pkg::IDX_SEQ) begin
            seq_reg <= rx_byte;
         end
         if (in_pan) begin
            pan_own_reg <= pan_own_reg && rx_byte == own_pan_b;
            pan_bc_reg <= pan_bc_reg && is_bcast;
         end
         if (in_short || in_ext) begin
            adr_own_reg <= adr_own_reg && rx_byte == own_adr_b;
            adr_bc_reg <= adr_bc_reg && is_bcast;
         end
      end
   end

   // Result flags change only at frame end, so software reads a stable verdict.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         crc_ok_reg <= 1'b0;
         match_reg <= 1'b0;
      end else if (rx_last) begin
         crc_ok_reg <= rcrc_next == 16'h0000;
         match_reg <= assist_on && pan_ok && adr_ok;
      end
   end

   assign frame_begin_event_o = begin_pulse_reg;

   // Memory port.
   // Receive writes have priority; transmit and receive never overlap in time.
   always_comb begin
      mem_req_o.addr = pf_addr;
      mem_req_o.wdata = rx_byte;
      mem_req_o.we = 1'b0;
      mem_req_o.re = tx_prefetch;
      if (len_take) begin
         mem_req_o.addr = ptr_reg;
         mem_req_o.we = 1'b1;
         mem_req_o.re = 1'b0;
      end else if (data_take) begin
         mem_req_o.addr = ptr_reg + 32'h1 + {24'h0, idx_reg};
         mem_req_o.we = 1'b1;
         mem_req_o.re = 1'b0;
      end
   end

   // Register file.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_reg <= lowrate_pan_pkg::CTRL_RESET;
         sfd_reg <= lowrate_pan_pkg::SFD_RESET;
         ptr_reg <= 32'h0;
         freq_reg <= lowrate_pan_pkg::FREQ_RESET;
         pan_reg <= 16'hffff;
         short_reg <= 16'hffff;
         ext_reg <= 64'h0;
      end else begin
         if (wr_ctrl) ctrl_reg <= reg_wdata_i[3:0];
         if (wr_sfd) sfd_reg <= reg_wdata_i[7:0];
         if (wr_ptr) ptr_reg <= reg_wdata_i;
         if (wr_freq) freq_reg <= reg_wdata_i[6:0];
         if (wr_pan) pan_reg <= reg_wdata_i[15:0];
         if (wr_short) short_reg <= reg_wdata_i[15:0];
         if (wr_extlo) ext_reg[31:0] <= reg_wdata_i;
         if (wr_exthi) ext_reg[63:32] <= reg_wdata_i;
      end
   end

   // Event flags: write one to clear, a new event in the same cycle wins.
   wire [2:0] ev_set = {byte_end && tx_last, rx_last, len_take};
   assign events_next = (events_reg & ~(wr_events ? reg_wdata_i[2:0] : 3'h0)) | ev_set;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         events_reg <= 3'h0;
      end else begin
         events_reg <= events_next;
      end
   end

   assign freq_setting_o = freq_reg;

   lowrate_pan_pkg::fcf_info_t fcf_info;
   assign fcf_info.frame_type = fcf_lo_reg[2:0];
   assign fcf_info.ack_req = fcf_lo_reg[5];
   assign fcf_info.dst_mode = dst_mode;

   wire [31:0] status_word = {5'h0, phr_reg, seq_reg, 1'b0, fcf_info, match_reg,
      rx_state_reg != RX_HUNT, tx_busy_reg, crc_ok_reg};

   logic [31:0] rd_mux;
   always_comb begin
      case (reg_addr_i)
         lowrate_pan_pkg::REG_CTRL: rd_mux = {28'h0, ctrl_reg};
         lowrate_pan_pkg::REG_SFD: rd_mux = {24'h0, sfd_reg};
         lowrate_pan_pkg::REG_FRAME_PTR: rd_mux = ptr_reg;
         lowrate_pan_pkg::REG_FREQ: rd_mux = {25'h0, freq_reg};
         lowrate_pan_pkg::REG_PAN_ID: rd_mux = {16'h0, pan_reg};
         lowrate_pan_pkg::REG_SHORT_ADDR: rd_mux = {16'h0, short_reg};
         lowrate_pan_pkg::REG_EXT_LO: rd_mux = ext_reg[31:0];
         lowrate_pan_pkg::REG_EXT_HI: rd_mux = ext_reg[63:32];
         lowrate_pan_pkg::REG_STATUS: rd_mux = status_word;
         lowrate_pan_pkg::REG_EVENTS: rd_mux = {29'h0, events_reg};
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 32'h0;
      end else if (reg_read_i) begin
         reg_rdata_o <= rd_mux;
      end else begin
         reg_rdata_o <= 32'h0;
      end
   end

endmodule

//--- lowrate_pan_chk.sv
// Purpose: Port-level checks on the low-rate PAN frame handler.
// Assumes: One clock, asynchronous active-high reset.
// Notes: A cycle counter tracks position inside a sent frame.
module lowrate_pan_chk (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   input wire logic [31:0] reg_rdata_o,
   input wire lowrate_pan_pkg::mem_req_t mem_req_o,
   input wire logic [7:0] mem_rdata_i,
   input wire logic rx_bit_i,
   input wire logic rx_strobe_i,
   input wire logic tx_bit_o,
   input wire logic tx_active_o,
   input wire logic [6:0] freq_setting_o,
   input wire logic frame_begin_event_o
);
   logic [15:0] txc;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) txc <= 16'h0;
      else if (tx_active_o) txc <= txc + 16'h1;
      else txc <= 16'h0;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_rdata_idle: assert property (!reg_read_i |=> reg_rdata_o == 32'h0)
      else $error("read data not zero outside a read");
   a_preamble_zero: assert property (tx_active_o && txc < 16'h500 |-> !tx_bit_o)
      else $error("preamble bit not zero");
   a_bit_stands: assert property (tx_active_o && txc % 16'h28 != 16'h0 |-> $stable(tx_bit_o))
      else $error("transmit bit changed inside its slot");
   a_whole_octets: assert property ($fell(tx_active_o) |->
      $past(txc) % 16'h140 == 16'h13f && $past(txc) >= 16'h77f)
      else $error("frame did not end on an octet boundary");
   a_freq_store: assert property (reg_write_i && reg_addr_i == lowrate_pan_pkg::REG_FREQ
      |=> freq_setting_o == $past(reg_wdata_i[6:0]))
      else $error("frequency setting not stored");
   a_begin_single: assert property (frame_begin_event_o |=> !frame_begin_event_o)
      else $error("begin event longer than one cycle");
   a_begin_cause: assert property (frame_begin_event_o |->
      $past(mem_req_o.we) && $past(mem_req_o.wdata[6:0]) != 7'h0)
      else $error("begin event without a nonzero length header write");
   a_status_pad: assert property (reg_read_i && reg_addr_i == lowrate_pan_pkg::REG_STATUS
      |=> reg_rdata_o[31:27] == 5'h0 && !reg_rdata_o[10])
      else $error("status padding bits not zero");
   a_read_in_tx: assert property (mem_req_o.re |-> tx_active_o)
      else $error("buffer read outside a transmission");
   a_write_pulse: assert property (mem_req_o.we |-> !tx_active_o ##1 !mem_req_o.we)
      else $error("buffer write during transmit or too long");
   c_begin: cover property (frame_begin_event_o);
   c_tx_end: cover property ($fell(tx_active_o));
   c_status: cover property (reg_read_i && reg_addr_i == lowrate_pan_pkg::REG_STATUS);
endmodule
bind lowrate_pan_frame_phy lowrate_pan_chk chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
   .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .mem_req_o(mem_req_o),
   .mem_rdata_i(mem_rdata_i), .rx_bit_i(rx_bit_i), .rx_strobe_i(rx_strobe_i),
   .tx_bit_o(tx_bit_o), .tx_active_o(tx_active_o), .freq_setting_o(freq_setting_o),
   .frame_begin_event_o(frame_begin_event_o));

//--- remote_node.sv
// Purpose: Remote low-rate PAN node that sends frames over the air.
// Assumes: Bits reach the block already demodulated, one strobe per bit.
// Notes: Ten cycles per bit keeps the data stable well around the strobe.
module remote_node (
   input wire logic clk_i,
   output logic rx_bit_o,
   output logic rx_strobe_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic busy = 1'b0;
   initial begin
      rx_bit_o = 1'b0;
      rx_strobe_o = 1'b0;
   end
   // Idle line carries noise.
   always @(posedge clk_i) if (!busy) rx_bit_o <= ~rx_bit_o;
   task automatic send_octet(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         rx_bit_o <= b[i];
         repeat (3) @(posedge clk_i);
         rx_strobe_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         rx_strobe_o <= 1'b0;
         repeat (2) @(posedge clk_i);
      end
   endtask
   task automatic send_frame(input logic [7:0] sfd, input logic [7:0] phr, input logic [7:0] pl[$]);
      busy = 1'b1;
      repeat (4) send_octet(8'h00);
      send_octet(sfd);
      send_octet(phr);
      foreach (pl[i]) send_octet(pl[i]);
      busy = 1'b0;
   endtask
endmodule

//--- test_lowrate_pan_frame_phy.sv
// Purpose: Self-checking bench for the low-rate PAN frame handler.
// Assumes: The frame buffer lives here and answers reads a cycle later.
// Notes: Frames are received from the remote node model.
module test_lowrate_pan_frame_phy;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [31:0] reg_rdata;
   lowrate_pan_pkg::mem_req_t mem_req;
   logic [7:0] mem_rdata = 8'h0;
   logic rx_bit, rx_strobe, tx_bit, tx_active, frame_begin;
   logic [6:0] freq_setting;
   logic [7:0] mem [0:255];
   int failures = 0;
   int checked = 0;
   int begins = 0;
   always #50 clk = ~clk;
   lowrate_pan_frame_phy dut (.clk_i(clk), .sys_rst_i(sys_rst), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_write_i(reg_write), .reg_read_i(reg_read),
      .reg_rdata_o(reg_rdata), .mem_req_o(mem_req), .mem_rdata_i(mem_rdata), .rx_bit_i(rx_bit),
      .rx_strobe_i(rx_strobe), .tx_bit_o(tx_bit), .tx_active_o(tx_active),
      .freq_setting_o(freq_setting), .frame_begin_event_o(frame_begin));
   remote_node node (.clk_i(clk), .rx_bit_o(rx_bit), .rx_strobe_o(rx_strobe));
   // Idle read data toggles.
   always @(posedge clk) begin
      if (mem_req.we === 1'b1) mem[mem_req.addr[7:0]] <= mem_req.wdata;
      mem_rdata <= (mem_req.re === 1'b1) ? mem[mem_req.addr[7:0]] : ~mem_rdata;
      if (frame_begin === 1'b1) begins <= begins + 1;
   end
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'h0;
      foreach (q[i]) for (int b = 0; b < 8; b++) c = (c[0] ^ q[i][b]) ? (c >> 1) ^ 16'h8408 : c >> 1;
      return c;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic final_report;
      $display("failures %0d checked %0d", failures, checked);
      if (failures == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic test_reset_values;
      logic [31:0] d;
      rd(lowrate_pan_pkg::REG_SFD, d);
      chk(d, 32'ha7, "delimiter reset");
      rd(lowrate_pan_pkg::REG_CTRL, d);
      chk(d, 32'h0, "control reset");
      rd(8'h3c, d);
      chk(d, 32'h0, "unmapped read");
   endtask
   task automatic test_channels;
      for (int ch = 11; ch <= 26; ch++) begin
         wr(lowrate_pan_pkg::REG_FREQ, 32'(5 * ch - 10));
         #1 chk(32'(freq_setting), 32'(5 * ch - 10), "frequency");
      end
   endtask
   task automatic test_transmit;
      logic [7:0] exp[$];
      logic [7:0] got;
      logic [15:0] c;
      exp = {8'h00, 8'h00, 8'h00, 8'h00, 8'ha7, 8'h04, 8'h3c, 8'hc5};
      c = crc16(exp[6:$]);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
      mem[8'h80] = 8'h04;
      mem[8'h81] = 8'h3c;
      mem[8'h82] = 8'hc5;
      mem[8'h83] = 8'h11;
      mem[8'h84] = 8'h22;
      wr(lowrate_pan_pkg::REG_FRAME_PTR, 32'h80);
      wr(lowrate_pan_pkg::REG_TASK, 32'h1);
      #1 chk(32'(tx_active), 32'h1, "transmit start");
      repeat (20) @(posedge clk);
      foreach (exp[i]) begin
         for (int b = 0; b < 8; b++) begin
            got[b] = tx_bit;
            repeat (40) @(posedge clk);
         end
         chk({24'h0, got}, {24'h0, exp[i]}, "sent octet");
      end
      #1 chk(32'(tx_active), 32'h0, "transmit end");
   endtask
   task automatic rx_frame(input logic [7:0] sfd, input logic [7:0] phr, input logic [7:0] pl[$],
                           input logic hit);
      int b0;
      b0 = begins;
      mem[8'h40] = 8'hee;
      node.send_frame(sfd, phr, pl);
      repeat (20) @(posedge clk);
      chk(32'(begins - b0), 32'(hit), "begins");
      chk(32'(mem[8'h40]), hit ? 32'(phr) : 32'hee, "header");
      if (hit) foreach (pl[i]) chk(32'(mem[8'(65 + i)]), 32'(pl[i]), "payload");
   endtask
   task automatic test_receive;
      logic [7:0] pl[$];
      logic [7:0] e[$];
      logic [15:0] c;
      logic [31:0] d;
      wr(lowrate_pan_pkg::REG_FRAME_PTR, 32'h40);
      pl = {8'h01, 8'h00, 8'h5e};
      c = crc16(pl);
      pl.push_back(c[7:0]);
      pl.push_back(c[15:8]);
      rx_frame(8'ha7, 8'h85, pl, 1'b1);
      rd(lowrate_pan_pkg::REG_STATUS, d);
      chk(d, {5'h0, 8'h85, 8'h5e, 1'b0, 3'h1, 1'b0, 2'h0, 4'h1}, "status");
      rx_frame(8'ha7, 8'h00, e, 1'b0);
      rx_frame(8'ha7, 8'h80, e, 1'b0);
      pl[4] = ~pl[4];
      rx_frame(8'ha7, 8'h85, pl, 1'b1);
      rd(lowrate_pan_pkg::REG_STATUS, d);
      chk(32'(d[0]), 32'h0, "bad crc");
      wr(lowrate_pan_pkg::REG_SFD, 32'h5a);
      rx_frame(8'ha7, 8'h85, pl, 1'b0);
      rx_frame(8'h5a, 8'h85, pl, 1'b1);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      test_reset_values();
      wr(lowrate_pan_pkg::REG_CTRL, 32'hf);
      test_channels();
      test_transmit();
      test_receive();
      final_report();
   end
   initial begin
      repeat (30000) @(posedge clk);
      failures++;
      final_report();
   end
endmodule
